// *** hdl/fcbc_pkg.sv ***
// fcbc_pkg: opcodes, register addresses, bit positions and state types
// for the flash command-behaviour configuration block.
// assumes a command front end that has already framed each spi command.
package fcbc_pkg;

   // ***************************************************
   // opcodes seen by the block
   // ***************************************************
   localparam logic [7:0] OP_READ_ANY     = 8'h65;
   localparam logic [7:0] OP_WRITE_ANY    = 8'h71;
   localparam logic [7:0] OP_SET_BURST    = 8'hc0;
   localparam logic [7:0] OP_RESUME_CLEAR = 8'h30;
   localparam logic [7:0] OP_LEGACY_RST   = 8'hf0;
   localparam logic [7:0] OP_RST_ENABLE   = 8'h66;
   localparam logic [7:0] OP_RST_EXEC     = 8'h99;
   localparam logic [7:0] OP_PARAM_ERASE  = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE  = 8'hd8;
   localparam logic [7:0] OP_BLOCK_ERASE4 = 8'hdc;
   localparam logic [7:0] OP_BULK_ERASE   = 8'h60;
   localparam logic [7:0] OP_BULK_ERASE2  = 8'hc7;

   // ***************************************************
   // register addresses for read-any / write-any
   // ***************************************************
   localparam logic [23:0] ADDR_CMD_BEHAV_V  = 24'h800004;
   localparam logic [23:0] ADDR_BURST_WRAP_V = 24'h800005;

   // ***************************************************
   // field positions and masks
   // ***************************************************
   localparam int unsigned BIT_BLANK_CHECK = 5;
   localparam int unsigned BIT_PGBUF_WRAP  = 4;
   localparam int unsigned BIT_SMALL_SEC   = 3;
   localparam int unsigned BIT_RESUME_SEL  = 2;
   localparam int unsigned BIT_BLOCK_SIZE  = 1;
   localparam int unsigned BIT_LEGACY_RST  = 0;
   localparam int unsigned BIT_WRAP_DIS    = 4;
   localparam logic [7:0] CMD_BEHAV_WR_MASK = 8'h37; // rw bits
   localparam logic [7:0] CMD_BEHAV_NV_MASK = 8'h3f; // no reserved
   localparam logic [7:0] BURST_WR_MASK     = 8'hf3;
   localparam logic [7:0] REG_ZERO          = 8'h00;

   // ***************************************************
   // page buffer geometry
   // ***************************************************
   localparam int unsigned PGBUF_AW = 9;
   localparam logic [7:0] PG_LOW_STEP = 8'h01;
   localparam logic [8:0] PG_STEP     = 9'h001;
   localparam logic [8:0] PG_ZERO     = 9'h000;

   // ***************************************************
   // state types
   // ***************************************************
   typedef enum logic {ERS_IDLE, ERS_SCAN} fcbc_ers_state_t;

   typedef struct packed {
      fcbc_ers_state_t state;
      logic            go;
      logic            skip;
   } fcbc_ers_st_t;

   typedef struct packed {
      logic [8:0] addr;
   } fcbc_pg_st_t;

   typedef struct packed {
      logic [7:0] cmd_behav;
      logic [7:0] burst;
      logic [7:0] rdata;
      logic       rvalid;
      logic       rst_armed;
      logic       swrst;
      logic       resume;
      logic       clr_status;
      logic       erase_start;
      logic       erase_256k;
   } fcbc_top_st_t;

endpackage

// *** hdl/fcbc_erase_seq.sv ***
// fcbc_erase_seq: blank-check sequencer in front of the erase engine.
// assumes the array reader answers scan_req_o with one word per
// scan_valid_i, flags any zero bit, and marks the sector's last word.
`timescale 1ns/10ps
`default_nettype none
module fcbc_erase_seq (
   input  wire logic sys_clk_i,        // system clock
   input  wire logic rst_i,            // sync reset, high
   input  wire logic abort_i,          // software reset
   input  wire logic start_i,          // erase command accepted
   input  wire logic blank_check_en_i, // blank check on
   input  wire logic prev_erase_ok_i,  // sector erase status good
   input  wire logic scan_valid_i,     // scanned word ready
   input  wire logic scan_zero_i,      // word holds a zero bit
   input  wire logic scan_last_i,      // last word of sector
   output logic      scan_req_o,       // read sector for check
   output logic      erase_go_o,       // start real erase, pulse
   output logic      erase_skip_o      // sector blank, pulse
);

   // ***************************************************
   // state
   // ***************************************************
   fcbc_pkg::fcbc_ers_st_t s_reg;  // registered state
   fcbc_pkg::fcbc_ers_st_t s_next; // next state

   // next-state logic
   always_comb begin
      s_next      = s_reg;
      s_next.go   = 1'b0;
      s_next.skip = 1'b0;
      case (s_reg.state)
         fcbc_pkg::ERS_IDLE: begin
            if (start_i) begin
               // check off, or last erase failed: erase at once
               if (!blank_check_en_i || !prev_erase_ok_i) begin
                  s_next.go = 1'b1;
               end else begin
                  s_next.state = fcbc_pkg::ERS_SCAN;
               end
            end
         end
         fcbc_pkg::ERS_SCAN: begin
            // first zero seen ends the scan early
            if (scan_valid_i && scan_zero_i) begin
               s_next.go    = 1'b1;
               s_next.state = fcbc_pkg::ERS_IDLE;
            end else if (scan_valid_i && scan_last_i) begin
               s_next.skip  = 1'b1;
               s_next.state = fcbc_pkg::ERS_IDLE;
            end
         end
         default: begin
            s_next.state = fcbc_pkg::ERS_IDLE;
         end
      endcase
      // a software reset drops any scan in progress
      if (rst_i || abort_i) begin
         s_next = '{state: fcbc_pkg::ERS_IDLE, go: 1'b0, skip: 1'b0};
      end
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      s_reg <= s_next;
   end

   assign scan_req_o   = (s_reg.state == fcbc_pkg::ERS_SCAN);
   assign erase_go_o   = s_reg.go;
   assign erase_skip_o = s_reg.skip;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i || abort_i);

   sequence ers_start_checked;
      !scan_req_o && start_i && blank_check_en_i && prev_erase_ok_i;
   endsequence

   sequence ers_blank_found;
      scan_valid_i && !scan_zero_i && scan_last_i;
   endsequence

   no_check_direct_a: assert property (
      (!scan_req_o && start_i && !blank_check_en_i) |=> erase_go_o)
      else $error("erase did not start with blank check off");
   failed_prev_a: assert property (
      (!scan_req_o && start_i && blank_check_en_i && !prev_erase_ok_i)
      |=> (erase_go_o && !scan_req_o))
      else $error("failed sector was scanned instead of erased");
   blank_skip_a: assert property (
      (ers_start_checked ##1 ers_blank_found) |=> (erase_skip_o
      && !erase_go_o))
      else $error("blank sector was not skipped");

endmodule
`default_nettype wire

// *** hdl/fcbc_pgbuf_addr.sv ***
// fcbc_pgbuf_addr: load address of the program page buffer.
// assumes one load_byte_i per data byte and load_start_i per command.
`timescale 1ns/10ps
`default_nettype none
module fcbc_pgbuf_addr (
   input  wire logic       sys_clk_i,    // system clock
   input  wire logic       rst_i,        // sync reset, high
   input  wire logic       load_start_i, // program command begins
   input  wire logic [8:0] start_off_i,  // first buffer offset
   input  wire logic       load_byte_i,  // one byte stored
   input  wire logic       wrap512_i,    // 1: whole 512-byte buffer
   output logic      [8:0] buf_addr_o    // current load offset
);

   // ***************************************************
   // state
   // ***************************************************
   fcbc_pkg::fcbc_pg_st_t s_reg;  // registered offset
   fcbc_pkg::fcbc_pg_st_t s_next; // next offset

   // offset step; 256 mode keeps bit 8 clear so it folds to zero
   always_comb begin
      s_next = s_reg;
      if (rst_i) begin
         s_next.addr = fcbc_pkg::PG_ZERO;
      end else if (load_start_i) begin
         s_next.addr = wrap512_i ? start_off_i
                                 : {1'b0, start_off_i[7:0]};
      end else if (load_byte_i) begin
         if (wrap512_i) begin
            s_next.addr = s_reg.addr + fcbc_pkg::PG_STEP;
         end else begin
            s_next.addr = {1'b0, s_reg.addr[7:0]
                                 + fcbc_pkg::PG_LOW_STEP};
         end
      end
   end

   // offset register
   always_ff @(posedge sys_clk_i) begin
      s_reg <= s_next;
   end

   assign buf_addr_o = s_reg.addr;

   // ***************************************************
   // checks
   // ***************************************************
   wrap_256_a: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (load_byte_i && !load_start_i && !wrap512_i
       && buf_addr_o[7:0] == 8'hff) |=> (buf_addr_o == 9'h000))
      else $error("256-byte wrap missed");
   nowrap_512_a: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (load_byte_i && !load_start_i && wrap512_i
       && buf_addr_o == 9'h0ff) |=> (buf_addr_o == 9'h100))
      else $error("512 mode wrapped at 256");

endmodule
`default_nettype wire

// *** hdl/fcbc_top.sv ***
// fcbc_top: volatile command-behaviour and burst-wrap registers of a
// serial nor flash, with the opcode steering that they control.
// assumes a spi front end that delivers each framed command as one
// cmd_valid_i cycle, and non-volatile copies held steady outside.
`timescale 1ns/10ps
`default_nettype none

module fcbc_top (
   input  wire logic        sys_clk_i,        // 20 MHz clock
   input  wire logic        rst_i,            // power-on/hw reset
   // framed command from the spi front end
   input  wire logic        cmd_valid_i,      // one cycle per command
   input  wire logic [7:0]  cmd_opcode_i,     // opcode byte
   input  wire logic [23:0] cmd_addr_i,       // register address
   input  wire logic [7:0]  cmd_wdata_i,      // write data byte
   output logic      [7:0]  rd_data_o,        // register read data
   output logic             rd_valid_o,       // read data pulse
   // non-volatile copies
   input  wire logic [7:0]  cmd_behav_nv_i,   // behaviour copy
   input  wire logic [7:0]  burst_nv_i,       // burst-wrap copy
   // erase path
   input  wire logic        prev_erase_ok_i,  // sector erase status
   input  wire logic        scan_valid_i,     // scanned word ready
   input  wire logic        scan_zero_i,      // word has a zero
   input  wire logic        scan_last_i,      // last sector word
   output logic             scan_req_o,       // blank scan active
   output logic             erase_go_o,       // start erase pulse
   output logic             erase_skip_o,     // erase skipped pulse
   output logic             erase_256k_o,     // block size of erase
   output logic             uniform_sectors_o,// 1: no 4-kB sectors
   // page buffer loading
   input  wire logic        load_start_i,     // program begins
   input  wire logic [8:0]  start_off_i,      // first offset
   input  wire logic        load_byte_i,      // byte stored
   output logic      [8:0]  buf_addr_o,       // load offset
   // command results
   output logic             resume_o,         // resume pulse
   output logic             clear_status_o,   // clear status pulse
   output logic             sw_reset_o,       // software reset pulse
   // burst wrap for reads
   input  wire logic        array_read_i,     // read targets array
   output logic             wrap_active_o,    // apply wrapping
   output logic      [1:0]  wrap_len_o        // wrap length code
);

   // ***************************************************
   // state
   // ***************************************************
   fcbc_pkg::fcbc_top_st_t s_reg;  // registered state
   fcbc_pkg::fcbc_top_st_t s_next; // next state

   logic op_is_erase; // any blank-checkable erase opcode
   logic op_is_block; // d8h or dch
   logic cmd_reset;   // software reset recognised this cycle

   // ***************************************************
   // opcode decode
   // ***************************************************
   // erase opcodes that share the blank-check path
   always_comb begin
      op_is_block = (cmd_opcode_i == fcbc_pkg::OP_BLOCK_ERASE)
                 || (cmd_opcode_i == fcbc_pkg::OP_BLOCK_ERASE4);
      op_is_erase = op_is_block
                 || (cmd_opcode_i == fcbc_pkg::OP_PARAM_ERASE)
                 || (cmd_opcode_i == fcbc_pkg::OP_BULK_ERASE)
                 || (cmd_opcode_i == fcbc_pkg::OP_BULK_ERASE2);
   end

   // software reset: legacy single opcode, or the armed pair
   always_comb begin
      cmd_reset = 1'b0;
      if (cmd_valid_i) begin
         if (cmd_opcode_i == fcbc_pkg::OP_LEGACY_RST) begin
            // ignored unless the legacy option is set
            cmd_reset = s_reg.cmd_behav[fcbc_pkg::BIT_LEGACY_RST];
         end else if (cmd_opcode_i == fcbc_pkg::OP_RST_EXEC) begin
            cmd_reset = s_reg.rst_armed;
         end
      end
   end

   // ***************************************************
   // next-state logic
   // ***************************************************
   always_comb begin
      s_next             = s_reg;
      // pulses last one cycle
      s_next.rvalid      = 1'b0;
      s_next.swrst       = 1'b0;
      s_next.resume      = 1'b0;
      s_next.clr_status  = 1'b0;
      s_next.erase_start = 1'b0;
      if (cmd_valid_i) begin
         // any command other than 66h cancels the arming
         s_next.rst_armed =
            (cmd_opcode_i == fcbc_pkg::OP_RST_ENABLE);
         case (cmd_opcode_i)
            fcbc_pkg::OP_READ_ANY: begin
               // unmapped addresses read as zero
               s_next.rvalid = 1'b1;
               if (cmd_addr_i == fcbc_pkg::ADDR_CMD_BEHAV_V) begin
                  s_next.rdata = s_reg.cmd_behav;
               end else if (cmd_addr_i == fcbc_pkg::ADDR_BURST_WRAP_V)
               begin
                  s_next.rdata = s_reg.burst;
               end else begin
                  s_next.rdata = fcbc_pkg::REG_ZERO;
               end
            end
            fcbc_pkg::OP_WRITE_ANY: begin
               if (cmd_addr_i == fcbc_pkg::ADDR_CMD_BEHAV_V) begin
                  // reserved bits drop, small-sector bit is held
                  s_next.cmd_behav =
                     (cmd_wdata_i & fcbc_pkg::CMD_BEHAV_WR_MASK)
                   | (s_reg.cmd_behav
                      & ~fcbc_pkg::CMD_BEHAV_WR_MASK
                      & fcbc_pkg::CMD_BEHAV_NV_MASK);
               end else if (cmd_addr_i == fcbc_pkg::ADDR_BURST_WRAP_V)
               begin
                  s_next.burst = cmd_wdata_i & fcbc_pkg::BURST_WR_MASK;
               end
            end
            fcbc_pkg::OP_SET_BURST: begin
               // set-burst-length writes the same register
               s_next.burst = cmd_wdata_i
                            & fcbc_pkg::BURST_WR_MASK;
            end
            fcbc_pkg::OP_RESUME_CLEAR: begin
               // one opcode, two meanings, chosen by the register
               if (s_reg.cmd_behav[fcbc_pkg::BIT_RESUME_SEL]) begin
                  s_next.resume = 1'b1;
               end else begin
                  s_next.clr_status = 1'b1;
               end
            end
            default: begin
               if (op_is_erase) begin
                  s_next.erase_start = 1'b1;
                  // size only matters for d8h/dch; others report 64 kB
                  s_next.erase_256k  = op_is_block
                     && s_reg.cmd_behav[fcbc_pkg::BIT_BLOCK_SIZE];
               end
            end
         endcase
      end
      // resets reload both volatile registers from their copies
      if (rst_i || cmd_reset) begin
         s_next.cmd_behav  = cmd_behav_nv_i
                           & fcbc_pkg::CMD_BEHAV_NV_MASK;
         s_next.burst      = burst_nv_i;
         s_next.rst_armed  = 1'b0;
         s_next.resume     = 1'b0;
         s_next.clr_status = 1'b0;
         s_next.erase_start= 1'b0;
         s_next.erase_256k = 1'b0;
      end
      if (rst_i) begin
         s_next.rdata  = fcbc_pkg::REG_ZERO;
         s_next.rvalid = 1'b0;
      end
      s_next.swrst = cmd_reset && !rst_i;
   end

   // state register; reset is synchronous through the comb path
   always_ff @(posedge sys_clk_i) begin
      s_reg <= s_next;
   end

   // ***************************************************
   // helpers
   // ***************************************************
   // the erase sequencer and page buffer read live register bits,
   // so a write takes effect on the next command without a restart
   fcbc_erase_seq u_erase (
      .sys_clk_i        (sys_clk_i),
      .rst_i            (rst_i),
      .abort_i          (s_reg.swrst),
      .start_i          (s_reg.erase_start),
      .blank_check_en_i (s_reg.cmd_behav[fcbc_pkg::BIT_BLANK_CHECK]),
      .prev_erase_ok_i  (prev_erase_ok_i),
      .scan_valid_i     (scan_valid_i),
      .scan_zero_i      (scan_zero_i),
      .scan_last_i      (scan_last_i),
      .scan_req_o       (scan_req_o),
      .erase_go_o       (erase_go_o),
      .erase_skip_o     (erase_skip_o)
   );

   fcbc_pgbuf_addr u_pgbuf (
      .sys_clk_i    (sys_clk_i),
      .rst_i        (rst_i),
      .load_start_i (load_start_i),
      .start_off_i  (start_off_i),
      .load_byte_i  (load_byte_i),
      .wrap512_i    (s_reg.cmd_behav[fcbc_pkg::BIT_PGBUF_WRAP]),
      .buf_addr_o   (buf_addr_o)
   );

   // ***************************************************
   // outputs
   // ***************************************************
   assign rd_data_o         = s_reg.rdata;
   assign rd_valid_o        = s_reg.rvalid;
   assign resume_o          = s_reg.resume;
   assign clear_status_o    = s_reg.clr_status;
   assign sw_reset_o        = s_reg.swrst;
   assign erase_256k_o      = s_reg.erase_256k;
   // map select follows the copy only, host writes cannot move it
   assign uniform_sectors_o =
      s_reg.cmd_behav[fcbc_pkg::BIT_SMALL_SEC];
   // wrap enable is active low; register and otp reads never wrap
   assign wrap_active_o     = array_read_i
      && !s_reg.burst[fcbc_pkg::BIT_WRAP_DIS];
   assign wrap_len_o        = s_reg.burst[1:0];

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence rst_arm_seq;
      cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_RST_ENABLE;
   endsequence

   sequence rst_exec_seq;
      cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_RST_EXEC;
   endsequence

   sequence op30_seq;
      cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_RESUME_CLEAR;
   endsequence

   reset_pair_a: assert property (
      (rst_arm_seq ##1 rst_exec_seq) |=> sw_reset_o)
      else $error("66h then 99h gave no reset");
   legacy_off_a: assert property (
      (cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_LEGACY_RST
       && !s_reg.cmd_behav[fcbc_pkg::BIT_LEGACY_RST]) |=> !sw_reset_o)
      else $error("f0h reset while disabled");
   legacy_on_a: assert property (
      (cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_LEGACY_RST
       && s_reg.cmd_behav[fcbc_pkg::BIT_LEGACY_RST]) |=> sw_reset_o)
      else $error("f0h reset missing while enabled");
   op30_resume_a: assert property (
      (op30_seq ##0 s_reg.cmd_behav[fcbc_pkg::BIT_RESUME_SEL])
      |=> (resume_o && !clear_status_o))
      else $error("30h not decoded as resume");
   op30_clear_a: assert property (
      (op30_seq ##0 !s_reg.cmd_behav[fcbc_pkg::BIT_RESUME_SEL])
      |=> (clear_status_o && !resume_o))
      else $error("30h not decoded as clear status");
   read_back_a: assert property (
      (cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_READ_ANY
       && cmd_addr_i == fcbc_pkg::ADDR_CMD_BEHAV_V)
      |=> (rd_valid_o && rd_data_o == $past(s_reg.cmd_behav)))
      else $error("register read returned wrong data");
   reserved_zero_a: assert property (
      s_reg.cmd_behav[7:6] == 2'b00)
      else $error("reserved bits not zero");
   small_sec_hold_a: assert property (
      (cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_WRITE_ANY
       && !cmd_reset) |=> $stable(uniform_sectors_o))
      else $error("small-sector bit changed by a write");
   burst_set_a: assert property (
      (cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_SET_BURST)
      |=> (s_reg.burst == ($past(cmd_wdata_i) & fcbc_pkg::BURST_WR_MASK)))
      else $error("burst length write lost");
   reload_a: assert property (
      sw_reset_o |-> (s_reg.cmd_behav
       == ($past(cmd_behav_nv_i) & fcbc_pkg::CMD_BEHAV_NV_MASK)))
      else $error("software reset did not reload copy");
   block_size_a: assert property (
      (cmd_valid_i && cmd_opcode_i == fcbc_pkg::OP_BLOCK_ERASE
       && !cmd_reset) |=> (erase_256k_o
       == $past(s_reg.cmd_behav[fcbc_pkg::BIT_BLOCK_SIZE])))
      else $error("block erase size wrong");
   wrap_array_a: assert property (
      !array_read_i |-> !wrap_active_o)
      else $error("non-array read wrapped");

endmodule
`default_nettype wire

// *** testbench/fcbc_host_model.sv ***
// fcbc_host_model: spi host side, one framed command per send call.
// assumes the block samples the command on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module fcbc_host_model (
   input  wire logic   sys_clk_i,    // system clock
   output logic        cmd_valid_o,  // command strobe
   output logic [7:0]  cmd_opcode_o, // opcode byte
   output logic [23:0] cmd_addr_o,   // register address
   output logic [7:0]  cmd_wdata_o   // write data
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_opcode_o = 8'h00;
      cmd_addr_o = 24'h000000;
      cmd_wdata_o = 8'h00;
   end
   // one strobe cycle; 65h reads, 71h writes
   // no write can clear the small-sector bit; only a reload from its copy moves it
   task automatic send(input logic [7:0] op, input logic [23:0] a,
                       input logic [7:0] d);
      @(negedge sys_clk_i);
      cmd_valid_o = 1'b1;
      cmd_opcode_o = op;
      cmd_addr_o = a;
      cmd_wdata_o = d;
      @(negedge sys_clk_i);
      // released lines show the inverse, never the old value
      cmd_valid_o = 1'b0;
      cmd_opcode_o = ~op;
      cmd_addr_o = ~a;
      cmd_wdata_o = ~d;
   endtask
   // two commands on consecutive edges, strobe held high between
   task automatic send2(input logic [7:0] op1, input logic [7:0] op2);
      @(negedge sys_clk_i);
      cmd_valid_o = 1'b1;
      cmd_opcode_o = op1;
      @(negedge sys_clk_i);
      cmd_opcode_o = op2;
      @(negedge sys_clk_i);
      cmd_valid_o = 1'b0;
      cmd_opcode_o = ~op2;
   endtask
endmodule
`default_nettype wire

// *** testbench/fcbc_top_tb_top.sv ***
// fcbc_top_tb_top: self-checking bench of the behaviour register block.
// assumes fcbc_host_model as the command source.
`timescale 1ns/10ps
`default_nettype none
module fcbc_top_tb_top;
   logic clk = 1'b0, rst = 1'b1, ok = 1'b0, sv = 1'b0, sz = 1'b0;
   logic sl = 1'b0, ls = 1'b0, lb = 1'b0, ar = 1'b1;
   logic [7:0] nv = 8'hc8, bnv = 8'h12;
   logic cv, rv, sq, go, sk, b256, uni, res, clr, swr, wa;
   logic [7:0] op, wd, rd;
   logic [23:0] ad;
   logic [1:0] wl;
   logic [8:0] ba;
   logic [8:0] off = 9'h0fe;
   int failures = 0, total_checks = 0;
   always #25 clk = ~clk;
   fcbc_host_model HOST (.sys_clk_i(clk), .cmd_valid_o(cv),
      .cmd_opcode_o(op), .cmd_addr_o(ad), .cmd_wdata_o(wd));
   fcbc_top DUT (.sys_clk_i(clk), .rst_i(rst), .cmd_valid_i(cv),
      .cmd_opcode_i(op), .cmd_addr_i(ad), .cmd_wdata_i(wd),
      .rd_data_o(rd), .rd_valid_o(rv), .cmd_behav_nv_i(nv),
      .burst_nv_i(bnv), .prev_erase_ok_i(ok), .scan_valid_i(sv),
      .scan_zero_i(sz), .scan_last_i(sl), .scan_req_o(sq),
      .erase_go_o(go), .erase_skip_o(sk), .erase_256k_o(b256),
      .uniform_sectors_o(uni), .load_start_i(ls), .start_off_i(off),
      .load_byte_i(lb), .buf_addr_o(ba), .resume_o(res),
      .clear_status_o(clr), .sw_reset_o(swr), .array_read_i(ar),
      .wrap_active_o(wa), .wrap_len_o(wl));
   task automatic chk(input logic [8:0] s, input logic [8:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("ERROR %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic cmd(input logic [7:0] o, input logic [7:0] d);
      HOST.send(o, fcbc_pkg::ADDR_CMD_BEHAV_V, d);
   endtask
   // read back the register, data and strobe together
   task automatic rd_chk(input logic [7:0] e);
      cmd(fcbc_pkg::OP_READ_ANY, 8'h00);
      chk({rv, rd}, {1'b1, e});
   endtask
   task automatic t_reset;
      rd_chk(8'h08);
      chk(9'(uni), 9'h1);
      chk(9'({wa, wl}), 9'h2);
      HOST.send(fcbc_pkg::OP_READ_ANY, 24'h800006, 8'h00);
      chk(9'(rd), 9'h0);
   endtask
   // bit 3 written to zero must stay one
   task automatic t_write;
      cmd(fcbc_pkg::OP_WRITE_ANY, 8'hf7);
      rd_chk(8'h3f);
      cmd(fcbc_pkg::OP_RESUME_CLEAR, 8'h00);
      chk(9'({res, clr}), 9'h2);
      cmd(fcbc_pkg::OP_WRITE_ANY, 8'h00);
      cmd(fcbc_pkg::OP_RESUME_CLEAR, 8'h00);
      chk(9'({res, clr}), 9'h1);
   endtask
   task automatic t_swrst;
      cmd(fcbc_pkg::OP_LEGACY_RST, 8'h00);
      chk(9'(swr), 9'h0);
      cmd(fcbc_pkg::OP_WRITE_ANY, 8'h01);
      cmd(fcbc_pkg::OP_LEGACY_RST, 8'h00);
      chk(9'(swr), 9'h1);
      rd_chk(8'h08);
      cmd(fcbc_pkg::OP_RST_EXEC, 8'h00);
      chk(9'(swr), 9'h0);
      cmd(fcbc_pkg::OP_RST_ENABLE, 8'h00);
      cmd(fcbc_pkg::OP_RST_EXEC, 8'h00);
      chk(9'(swr), 9'h1);
   endtask
   // failed status, blank scan hit, blank skip, check off
   task automatic t_erase;
      cmd(fcbc_pkg::OP_WRITE_ANY, 8'h22);
      cmd(fcbc_pkg::OP_BLOCK_ERASE, 8'h00);
      chk(9'(b256), 9'h1);
      tick(1);
      chk(9'({sq, go}), 9'h1);
      ok = 1'b1;
      cmd(fcbc_pkg::OP_PARAM_ERASE, 8'h00);
      chk(9'(b256), 9'h0);
      tick(1);
      chk(9'({sq, go}), 9'h2);
      sv = 1'b1;
      sz = 1'b1;
      tick(1);
      sv = 1'b0;
      chk(9'({sq, go}), 9'h1);
      cmd(fcbc_pkg::OP_BULK_ERASE, 8'h00);
      tick(1);
      sv = 1'b1;
      sz = 1'b0;
      sl = 1'b1;
      tick(1);
      sv = 1'b0;
      chk(9'({sk, go}), 9'h2);
      cmd(fcbc_pkg::OP_WRITE_ANY, 8'h00);
      cmd(fcbc_pkg::OP_BULK_ERASE2, 8'h00);
      tick(1);
      chk(9'({sq, go}), 9'h1);
      cmd(fcbc_pkg::OP_WRITE_ANY, 8'h02);
      cmd(fcbc_pkg::OP_BLOCK_ERASE4, 8'h00);
      chk(9'(b256), 9'h1);
      cmd(fcbc_pkg::OP_WRITE_ANY, 8'h00);
      cmd(fcbc_pkg::OP_BLOCK_ERASE, 8'h00);
      chk(9'(b256), 9'h0);
   endtask
   // burst write by address, then a back-to-back reset pair reloads
   // both registers from their copies, with only the behaviour copy changed
   task automatic t_reload;
      ar = 1'b1;
      HOST.send(fcbc_pkg::OP_WRITE_ANY, fcbc_pkg::ADDR_BURST_WRAP_V, 8'hff);
      HOST.send(fcbc_pkg::OP_READ_ANY, fcbc_pkg::ADDR_BURST_WRAP_V, 8'h00);
      chk(9'(rd), 9'h0f3);
      chk(9'({wa, wl}), 9'h3);
      nv = 8'h00;
      HOST.send2(fcbc_pkg::OP_RST_ENABLE, fcbc_pkg::OP_RST_EXEC);
      chk(9'(swr), 9'h1);
      chk(9'({wa, wl}), 9'h2);
      chk(9'(uni), 9'h0);
      rd_chk(8'h00);
   endtask
   // two bytes past 0fe land at 000 or 100
   task automatic t_pgbuf(input logic [8:0] e);
      ls = 1'b1;
      tick(1);
      ls = 1'b0;
      lb = 1'b1;
      tick(2);
      lb = 1'b0;
      chk(ba, e);
   endtask
   task automatic t_burst;
      cmd(fcbc_pkg::OP_SET_BURST, 8'h03);
      chk(9'({wa, wl}), 9'h7);
      ar = 1'b0;
      tick(1);
      chk(9'(wa), 9'h0);
   endtask
   task automatic report_and_stop;
      if (failures == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #50us;
      failures++;
      report_and_stop;
   end
   initial begin
      tick(8);
      rst = 1'b0;
      t_reset;
      t_write;
      t_swrst;
      t_erase;
      t_pgbuf(9'h000);
      cmd(fcbc_pkg::OP_WRITE_ANY, 8'h10);
      t_pgbuf(9'h100);
      t_burst;
      t_reload;
      report_and_stop;
   end
endmodule
`default_nettype wire
